/* logic/ifr_pkg.sv */
// Purpose: Constants, register map and carrier types of the input function router.
// Assumes: APB slave with 32-bit data, one aligned word per register, clk at 200 MHz.
// Notes: Each logical function owns one 16-bit route word: high byte polarity, low byte port number.
//
// Functional notes
// - A route word of 0000 keeps its function off whatever the ports do.
// - A route word of 0100 keeps its function on whatever the ports do.
// - Words 0001 to 0008 make the function follow the chosen port, on while its isolator conducts.
// - Words 0101 to 0108 make the function follow the chosen port inverted, on while its isolator is dark.
// - Servo enable is hard wired to port 1 with active-on polarity and no setting can move it.
// - Any number of functions may pick the same port and each follows it on its own.
// - Active-off polarity with no port chosen leaves the function on for good, so a halt stays latched on.
// - After reset the mode pick function follows port 8 with active-on polarity.
// - With torque cap and mode pick both on port 8 active-on, conduction there turns both on together.
// - The gear pick output selects the second gear ratio while on and the first while off.
// - A conducting isolator counts as asserted for active-on polarity and as deasserted for active-off.
package ifr_pkg;

    // Sizes
    localparam int NUM_FUNC = 17;
    localparam int NUM_PORT = 8;
    localparam int ROUTE_W = 16;
    localparam int APB_ADDR_W = 8;

    // Register byte offsets; route word n sits at ROUTE_BASE + 4*n
    localparam logic [7:0] OFS_ROUTE_BASE = 8'h00;
    localparam logic [7:0] OFS_PORT_STATE = 8'h44;
    localparam logic [7:0] OFS_FUNC_STATE = 8'h48;
    localparam logic [5:0] IDX_ROUTE_LAST = 6'h10;
    localparam logic [5:0] IDX_PORT_STATE = 6'h11;
    localparam logic [5:0] IDX_FUNC_STATE = 6'h12;

    // Route word encodings
    localparam logic [15:0] CODE_FORCE_OFF = 16'h0000;
    localparam logic [15:0] CODE_FORCE_ON = 16'h0100;
    localparam logic [7:0] POL_ACTIVE_ON = 8'h00;
    localparam logic [7:0] POL_ACTIVE_OFF = 8'h01;
    localparam logic [7:0] PORT_FIRST = 8'h01;
    localparam logic [7:0] PORT_LAST = 8'h08;

    // Function indices
    localparam int FN_EMERGENCY_HALT = 0;
    localparam int FN_TORQUE_CAP = 13;
    localparam int FN_GEAR_PICK = 14;
    localparam int FN_MODE_PICK = 15;

    // Route values after reset, index 16 first
    localparam logic [NUM_FUNC-1:0][ROUTE_W-1:0] ROUTE_RST = {
        16'h0000, // position_cmd_block_route
        16'h0008, // mode_pick_route
        16'h0000, // gear_pick_route
        16'h0000, // torque_cap_route
        16'h0000, // speed_cap_pick_b_route
        16'h0000, // speed_cap_pick_a_route
        16'h0000, // speed_cmd_pick_b_route
        16'h0000, // speed_cmd_pick_a_route
        16'h0007, // rev_pick_route
        16'h0006, // fwd_pick_route
        16'h0007, // rev_allow_route
        16'h0006, // fwd_allow_route
        16'h0105, // rev_block_route
        16'h0104, // fwd_block_route
        16'h0003, // deviation_clear_route
        16'h0002, // alarm_clear_route
        16'h0000  // emergency_halt_route
    };

    // Routed function outputs; servo_enable on top, the rest in function index order
    typedef struct packed {
        logic servo_enable;
        logic position_cmd_block;
        logic mode_pick;
        logic gear_second_ratio;
        logic torque_cap;
        logic speed_cap_pick_b;
        logic speed_cap_pick_a;
        logic speed_cmd_pick_b;
        logic speed_cmd_pick_a;
        logic reverse_pick;
        logic forward_pick;
        logic reverse_allow;
        logic forward_allow;
        logic reverse_block;
        logic forward_block;
        logic deviation_clear;
        logic alarm_clear;
        logic emergency_halt;
    } ifr_func_t;

    // APB request and response
    typedef struct packed {
        logic [APB_ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ifr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ifr_apb_rsp_t;

    // Whole state of the router
    typedef struct packed {
        logic [NUM_PORT-1:0] sync_a;
        logic [NUM_PORT-1:0] sync_b;
        logic [NUM_FUNC-1:0][ROUTE_W-1:0] route;
        logic [NUM_FUNC-1:0] func;
        logic servo;
        logic [31:0] prdata;
    } ifr_state_t;

endpackage : ifr_pkg

/* logic/ifr_router.sv */
// Purpose: Routes eight isolated input ports onto seventeen logical functions plus servo enable.
// Assumes: port_in is high while a port's isolator conducts; APB master follows the usual two-phase protocol.
// Notes: Zero wait states; read data is captured in the setup cycle so it leaves a flip-flop.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module ifr_router (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Isolated input ports, bit 0 is port_1
    input wire [ifr_pkg::NUM_PORT-1:0] port_in,
    // Register bus
    input ifr_pkg::ifr_apb_req_t apb_req,
    output ifr_pkg::ifr_apb_rsp_t apb_rsp,
    // Routed functions
    output ifr_pkg::ifr_func_t func_out
);

    localparam ifr_pkg::ifr_state_t ST_RST = '{
        sync_a: '0,
        sync_b: '0,
        route: ifr_pkg::ROUTE_RST,
        func: '0,
        servo: 1'b0,
        prdata: '0
    };

    ifr_pkg::ifr_state_t st_reg;
    ifr_pkg::ifr_state_t st_next;
    logic [ifr_pkg::NUM_FUNC-1:0] func_eval;
    logic [5:0] word_idx;
    logic is_route;
    logic is_mapped;
    logic setup_phase;
    logic access_phase;

    // Decode one route word against the synchronised port levels
    function automatic logic route_decode(input logic [15:0] word, input logic [7:0] ports);
        logic [7:0] pol;
        logic [7:0] sel;
        logic level;
        pol = word[15:8];
        sel = word[7:0];
        level = 1'b0;
        route_decode = 1'b0;
        if (word == ifr_pkg::CODE_FORCE_OFF) begin
            route_decode = 1'b0;
        end else if (word == ifr_pkg::CODE_FORCE_ON) begin
            route_decode = 1'b1;
        end else if (sel >= ifr_pkg::PORT_FIRST && sel <= ifr_pkg::PORT_LAST) begin
            level = ports[3'(sel - ifr_pkg::PORT_FIRST)];
            if (pol == ifr_pkg::POL_ACTIVE_ON) begin
                route_decode = level;
            end else if (pol == ifr_pkg::POL_ACTIVE_OFF) begin
                route_decode = ~level;
            end else begin
                route_decode = 1'b0;
            end
        end else begin
            route_decode = 1'b0;
        end
    endfunction : route_decode

    // One decoder per function; each reads the shared port vector on its own,
    // so any number of functions may follow the same port
    genvar g;
    generate
        for (g = 0; g < ifr_pkg::NUM_FUNC; g++) begin : g_func
            assign func_eval[g] = route_decode(st_reg.route[g], st_reg.sync_b);
        end
    endgenerate

    // Address decode, word aligned; low address bits are ignored
    assign word_idx = apb_req.paddr[7:2];
    assign is_route = (word_idx <= ifr_pkg::IDX_ROUTE_LAST);
    assign is_mapped = is_route || (word_idx == ifr_pkg::IDX_PORT_STATE) || (word_idx == ifr_pkg::IDX_FUNC_STATE);
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;

    // Next state: synchronisers, routing, register writes and read capture
    always_comb begin
        st_next = st_reg;
        st_next.sync_a = port_in;
        st_next.sync_b = st_reg.sync_a;
        st_next.func = func_eval;
        st_next.servo = st_reg.sync_b[0];
        // Capture read data in setup so the access cycle shows a registered word
        if (setup_phase) begin
            st_next.prdata = 32'h0000_0000;
            if (is_route) begin
                st_next.prdata = {16'h0000, st_reg.route[word_idx[4:0]]};
            end else if (word_idx == ifr_pkg::IDX_PORT_STATE) begin
                st_next.prdata = {24'h00_0000, st_reg.sync_b};
            end else if (word_idx == ifr_pkg::IDX_FUNC_STATE) begin
                st_next.prdata = {14'h0000, st_reg.servo, st_reg.func};
            end
        end
        // Byte-lane writes to route words; status words are read only
        if (access_phase && apb_req.pwrite && is_route) begin
            if (apb_req.pstrb[0]) begin
                st_next.route[word_idx[4:0]][7:0] = apb_req.pwdata[7:0];
            end
            if (apb_req.pstrb[1]) begin
                st_next.route[word_idx[4:0]][15:8] = apb_req.pwdata[15:8];
            end
        end
    end

    // Single state register; reset loads mode pick onto port 8 among the defaults
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus answer: always ready, error on unmapped words
    assign apb_rsp.prdata = st_reg.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access_phase && !is_mapped;

    // Function outputs, all from flip-flops; gear pick high means second ratio
    assign func_out = {st_reg.servo, st_reg.func};

endmodule : ifr_router

/* bench/ifr_host_port_model.sv */
// Purpose: Host side that drives the isolated input ports.
// Assumes: High means the isolator conducts.
// Notes: Ports move one edge after the bench asks, like a host output register.
`timescale 1ns/1ps
module ifr_host_port_model (
    // Clock
    input wire clk,
    // Wanted levels and driven ports
    input wire logic [7:0] want,
    output logic [7:0] port_in
);
    // Registered so ports never move at the sampling instant; one driver only
    always @(posedge clk) begin
        port_in <= want;
    end
endmodule : ifr_host_port_model

/* bench/ifr_router_sva.sv */
// Purpose: Port-level checks of the input function router.
// Assumes: Zero-wait APB; three-edge port latency.
// Notes: Route words are not visible here, so checks use servo, bus and reset.
`timescale 1ns/1ps
module ifr_router_sva (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Watched ports
    input wire [ifr_pkg::NUM_PORT-1:0] port_in,
    input ifr_pkg::ifr_apb_req_t apb_req,
    input ifr_pkg::ifr_apb_rsp_t apb_rsp,
    input ifr_pkg::ifr_func_t func_out
);
    logic [1:0] age_reg;
    logic [1:0] age_next;
    logic acc;
    logic bad;
    // Edges since release; the sync pipe holds stale zeros until three
    always_comb age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age_reg <= 2'h0;
        end else begin
            age_reg <= age_next;
        end
    end
    // Access phase and unmapped word
    assign acc = apb_req.psel && apb_req.penable;
    assign bad = apb_req.paddr[7:2] > ifr_pkg::IDX_FUNC_STATE;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_servo_lag: assert property (age_reg == 2'h3 |-> func_out.servo_enable == $past(port_in[0], 3))
        else $error("servo enable off its port");
    chk_ready_const: assert property (apb_rsp.pready) else $error("pready low");
    chk_err_unmapped: assert property (acc && bad |-> apb_rsp.pslverr) else $error("no slave error");
    chk_err_mapped: assert property (!(acc && !bad) || !apb_rsp.pslverr) else $error("stray error");
    chk_err_idle: assert property (!acc |-> !apb_rsp.pslverr) else $error("error outside access");
    chk_unmapped_zero: assert property (acc && bad && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_func_read: assert property (acc && !apb_req.pwrite && apb_req.paddr == 8'h48
        |-> apb_rsp.prdata == {14'h0, $past(func_out)}) else $error("function state read wrong");
    chk_port_upper: assert property (acc && !apb_req.pwrite && apb_req.paddr == 8'h44
        |-> apb_rsp.prdata[31:8] == 24'h0) else $error("port state upper bits set");
    chk_reset_quiet: assert property ($rose(arst_n) |-> func_out == '0) else $error("outputs live at release");
    // Main scenarios
    cover property (acc && bad);
    cover property (func_out.mode_pick && func_out.torque_cap);
    cover property (func_out.emergency_halt);
endmodule : ifr_router_sva
bind ifr_router ifr_router_sva u_sva (.clk(clk), .arst_n(arst_n), .port_in(port_in), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .func_out(func_out));

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the input function router.
// Assumes: Outputs follow the host request four edges later.
// Notes: Table rows set a route and ports; reset and odd cases follow.
`timescale 1ns/1ps
module tb_top;
    typedef struct {int f; logic [15:0] w; logic [7:0] p; logic x;} ifr_row_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] want = 8'h00;
    logic [7:0] port_in;
    ifr_pkg::ifr_apb_req_t req = '0;
    ifr_pkg::ifr_apb_rsp_t rsp;
    ifr_pkg::ifr_func_t fo;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic e;
    // Function, route word, ports, expected level
    ifr_row_t rows [10] = '{'{14, 16'h0000, 8'hff, 1'b0}, '{14, 16'h0100, 8'h00, 1'b1},
        '{3, 16'h0001, 8'h01, 1'b1}, '{3, 16'h0008, 8'h7f, 1'b0}, '{5, 16'h0108, 8'h80, 1'b0},
        '{5, 16'h0101, 8'h00, 1'b1}, '{0, 16'h0100, 8'hff, 1'b1}, '{9, 16'h0009, 8'hff, 1'b0},
        '{9, 16'h0200, 8'h00, 1'b0}, '{16, 16'h0005, 8'h10, 1'b1}};
    // 200 MHz
    always #2.5 clk = ~clk;
    ifr_host_port_model u_host (.clk(clk), .want(want), .port_in(port_in));
    ifr_router u_dut (.clk(clk), .arst_n(arst_n), .port_in(port_in), .apb_req(req), .apb_rsp(rsp), .func_out(fo));
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // One transfer; an edge passes first so psel is never set twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic s);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pstrb: 4'h3};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) begin
            err_count++;
            summarize();
        end
        r = rsp.prdata;
        s = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    // Ports reach the outputs four edges after a request
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, 8'(4 * rows[i].f), 32'(rows[i].w), q, e);
            want <= rows[i].p;
            repeat (6) @(posedge clk);
            chk("function", 32'(rows[i].x), 32'(fo[rows[i].f]));
        end
        // Second reset mid-run, then defaults
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("reset outputs", 32'h0, 32'(fo));
        arst_n <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, q, e);
            chk("route", 32'(ifr_pkg::ROUTE_RST[i]), q);
        end
        apb(1'b1, 8'h34, 32'h0008, q, e);
        want <= 8'h80;
        repeat (6) @(posedge clk);
        chk("shared port", 32'h3, {30'h0, fo.mode_pick, fo.torque_cap});
        want <= 8'h01;
        repeat (6) @(posedge clk);
        chk("servo", 32'h2, {30'h0, fo.servo_enable, fo.mode_pick});
        apb(1'b0, 8'h44, 32'h0, q, e);
        chk("port state", 32'h1, q);
        apb(1'b0, 8'h48, 32'h0, q, e);
        chk("function state", 32'h0002_0018, q);
        apb(1'b0, 8'h4c, 32'h0, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        summarize();
    end
endmodule : tb_top
